// ==== logic/dpc_clock_config.sv ====
// Clock multiplier configuration, clock routing and band autosearch
//
// Operation
// RULE1: With the enable bit of 0x09 clear, the reference clock goes straight to the sample clock.
// RULE2: With the multiplier bypassed, the data rate is the sample clock divided by the interpolation divider alone.
// RULE3: The band field is six bits; codes 0 to 62 pick fixed bands, code 63 picks automatic mode.
// RULE4: Software prefers the band that puts the wanted frequency at the top of its range.
// RULE5: A five-bit field sets the filter zero-pole from near 10 MHz (00000) to near 1 MHz (11111).
// RULE6: Software sets the filter field to 11111 and the bias field to 111 whenever the multiplier runs.
// RULE7: Bits 7:5 of 0x0A read back a three-bit image of the loop control voltage.
// RULE8: Software takes 010, 001 or 011 as healthy and anything else as a fault.
// RULE9: Writing code 63 to 0x08 bits 7:2 starts the band search, and the found band reads back there.
// RULE10: Software uses the search only to discover settings, then rewrites them manually.
// RULE11: With the enable bit of 0x09 set, the internal clocks come from the multiplier output.
// RULE12: With the multiplier running, interpolation and loop dividers fix reference to data rate.
// RULE13: Software picks the VCO divider to keep the VCO between 1.0 GHz and 2.0 GHz.
// RULE14: The band field sits in 0x08 bits 7:2 and is both writable and readable.
`timescale 1ns/1ns
`default_nettype none
module dpc_clock_config #(
    parameter int SETTLE_CYCLES = dpc_pkg::SETTLE_CYC
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic reg_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic ref_tick,
    input wire logic pll_tick,
    input wire logic [2:0] vtune_level,
    input wire logic [1:0] interp_sel,
    output logic sample_tick,
    output logic data_tick,
    output logic pll_enable,
    output logic [2:0] pll_bias,
    output logic [5:0] vco_band,
    output logic [4:0] filter_zero_code,
    output logic search_busy
);
    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    // The settle counter is 16 bits, so longer waits need a wider counter
    if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 65535) begin : g_bad_settle
        $error("SETTLE_CYCLES out of range");
    end
    // Field slices below assume the port widths; catch a package edit that breaks them
    if (dpc_pkg::BAND_MSB - dpc_pkg::BAND_LSB != 5) begin : g_bad_band
        $error("band field must be six bits wide");
    end
    if (dpc_pkg::BIAS_MSB - dpc_pkg::BIAS_LSB != 2) begin : g_bad_bias
        $error("bias field must be three bits wide");
    end
    if (dpc_pkg::FILT_MSB - dpc_pkg::FILT_LSB != 4) begin : g_bad_filt
        $error("filter field must be five bits wide");
    end
    if (dpc_pkg::VTUNE_MSB - dpc_pkg::VTUNE_LSB != 2) begin : g_bad_vtune
        $error("voltage image field must be three bits wide");
    end

    dpc_pkg::dpc_srch_e state;
    logic [15:0] settle_cnt;
    logic [5:0] band_try;
    logic [5:0] band_best;
    logic best_valid;
    logic [2:0] vtune_q;
    logic [2:0] div_cnt;
    logic [2:0] div_last;
    logic wr_band;
    logic vtune_good;
    logic settle_end;

    assign wr_band = reg_wr && reg_addr == dpc_pkg::OFS_VCO_BAND_SELECT;
    // Healthy window of the control voltage image, as software judges it
    assign vtune_good = vtune_level >= dpc_pkg::VTUNE_OK_LO && vtune_level <= dpc_pkg::VTUNE_OK_HI;
    assign settle_end = settle_cnt == 16'(SETTLE_CYCLES - 1);

    // Terminal count; the >= compare below recovers a count left high by a rate change
    always_comb begin
        unique case (interp_sel)
            2'b00: div_last = 3'h0;
            2'b01: div_last = 3'h1;
            2'b10: div_last = 3'h3;
            2'b11: div_last = 3'h7;
        endcase
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pll_enable <= dpc_pkg::RST_PLL_EN;
            pll_bias <= dpc_pkg::RST_BIAS;
            filter_zero_code <= dpc_pkg::RST_FILT;
        end else if (reg_wr && reg_addr == dpc_pkg::OFS_PLL_ENABLE_BIAS) begin
            pll_enable <= reg_wdata[dpc_pkg::PLL_EN_BIT];
            pll_bias <= reg_wdata[dpc_pkg::BIAS_MSB:dpc_pkg::BIAS_LSB];
        end else if (reg_wr && reg_addr == dpc_pkg::OFS_LOOP_FILTER_AND_VTUNE) begin
            // Bigger code switches in more capacitance, moving the zero down
            filter_zero_code <= reg_wdata[dpc_pkg::FILT_MSB:dpc_pkg::FILT_LSB]; // see RULE5
        end
    end

    // ------------------------------------------------------------
    // Band select and autosearch
    // ------------------------------------------------------------
    // Sweep runs upward and keeps the last good band, so the highest
    // band that locks wins: best phase noise for a doubly covered rate.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state <= dpc_pkg::SRCH_IDLE;
            settle_cnt <= 16'h0000;
            band_try <= 6'h00;
            band_best <= 6'h00;
            best_valid <= 1'b0;
            vco_band <= dpc_pkg::RST_BAND;
            search_busy <= 1'b0;
        end else if (wr_band) begin
            settle_cnt <= 16'h0000;
            band_try <= 6'h00;
            best_valid <= 1'b0;
            if (reg_wdata[dpc_pkg::BAND_MSB:dpc_pkg::BAND_LSB] == dpc_pkg::BAND_AUTO) begin
                state <= dpc_pkg::SRCH_SETTLE; // see RULE9
                vco_band <= 6'h00;
                search_busy <= 1'b1;
            end else begin
                // A manual code aborts any search in progress
                state <= dpc_pkg::SRCH_IDLE; // see RULE3
                vco_band <= reg_wdata[dpc_pkg::BAND_MSB:dpc_pkg::BAND_LSB]; // see RULE14
                search_busy <= 1'b0;
            end
        end else begin
            unique case (state)
                dpc_pkg::SRCH_IDLE: begin
                end
                dpc_pkg::SRCH_SETTLE: begin
                    settle_cnt <= settle_cnt + 16'h0001;
                    if (settle_end) begin
                        settle_cnt <= 16'h0000;
                        if (vtune_good) begin
                            band_best <= band_try;
                            best_valid <= 1'b1;
                        end
                        if (band_try == dpc_pkg::BAND_TOP) begin
                            state <= dpc_pkg::SRCH_DONE;
                        end else begin
                            band_try <= band_try + 6'h01;
                            vco_band <= band_try + 6'h01;
                        end
                    end
                end
                dpc_pkg::SRCH_DONE: begin
                    // No band locked: fall back to the lowest band
                    vco_band <= best_valid ? band_best : 6'h00; // see RULE9
                    search_busy <= 1'b0;
                    state <= dpc_pkg::SRCH_IDLE;
                end
                default: begin
                    state <= dpc_pkg::SRCH_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Clock routing and interpolation divider
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            sample_tick <= 1'b0;
        end else begin
            // Multiplier output tapped between VCO and loop dividers
            sample_tick <= pll_enable ? pll_tick : ref_tick; // see RULE1 see RULE11
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            div_cnt <= 3'h0;
            data_tick <= 1'b0;
        end else begin
            data_tick <= 1'b0;
            if (sample_tick) begin
                // Same divider in both modes; with the loop closed the loop
                // divider sets the sample rate, so the ratio follows
                if (div_cnt >= div_last) begin
                    div_cnt <= 3'h0;
                    data_tick <= 1'b1; // see RULE2 see RULE12
                end else begin
                    div_cnt <= div_cnt + 3'h1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Readback
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            vtune_q <= 3'h0;
            reg_rdata <= 8'h00;
        end else begin
            vtune_q <= vtune_level;
            // Unused bits of the band and enable registers read as zero
            unique case (reg_addr)
                dpc_pkg::OFS_VCO_BAND_SELECT:
                    reg_rdata <= {search_busy ? dpc_pkg::BAND_AUTO : vco_band, 2'b00}; // see RULE9
                dpc_pkg::OFS_PLL_ENABLE_BIAS:
                    reg_rdata <= {pll_enable, 4'h0, pll_bias};
                dpc_pkg::OFS_LOOP_FILTER_AND_VTUNE:
                    reg_rdata <= {vtune_q, filter_zero_code}; // see RULE7
                default:
                    reg_rdata <= 8'h00;
            endcase
        end
    end
endmodule : dpc_clock_config
`default_nettype wire

// ==== pkg/dpc_pkg.sv ====
// Constants for the converter clock multiplier configuration block
`default_nettype none
package dpc_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_VCO_BAND_SELECT = 8'h08;
    localparam logic [7:0] OFS_PLL_ENABLE_BIAS = 8'h09;
    localparam logic [7:0] OFS_LOOP_FILTER_AND_VTUNE = 8'h0a;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int BAND_LSB = 2;
    localparam int BAND_MSB = 7;
    localparam int PLL_EN_BIT = 7;
    localparam int BIAS_LSB = 0;
    localparam int BIAS_MSB = 2;
    localparam int FILT_LSB = 0;
    localparam int FILT_MSB = 4;
    localparam int VTUNE_LSB = 5;
    localparam int VTUNE_MSB = 7;
    // ------------------------------------------------------------
    // Codes and reset values
    // ------------------------------------------------------------
    localparam logic [5:0] BAND_AUTO = 6'h3f;
    localparam logic [5:0] BAND_TOP = 6'h3e;
    localparam logic [5:0] RST_BAND = 6'h00;
    localparam logic RST_PLL_EN = 1'b0;
    localparam logic [2:0] RST_BIAS = 3'h0;
    localparam logic [4:0] RST_FILT = 5'h00;
    localparam logic [2:0] VTUNE_OK_LO = 3'h1;
    localparam logic [2:0] VTUNE_OK_HI = 3'h3;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 50;
    localparam int SETTLE_US = 10;
    localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;
    // ------------------------------------------------------------
    // Autosearch states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        SRCH_IDLE = 3'b001,
        SRCH_SETTLE = 3'b010,
        SRCH_DONE = 3'b100
    } dpc_srch_e;
endpackage : dpc_pkg
`default_nettype wire

// ==== test/dpc_clock_config_chk.sv ====
// Port checker for the clock configuration block
`timescale 1ns/1ns
`default_nettype none
module dpc_clock_config_chk (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic reg_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic ref_tick,
    input wire logic pll_tick,
    input wire logic [2:0] vtune_level,
    input wire logic [1:0] interp_sel,
    input wire logic sample_tick,
    input wire logic data_tick,
    input wire logic pll_enable,
    input wire logic [2:0] pll_bias,
    input wire logic [5:0] vco_band,
    input wire logic [4:0] filter_zero_code,
    input wire logic search_busy
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    wire logic w_band = reg_wr && reg_addr == dpc_pkg::OFS_VCO_BAND_SELECT;
    wire logic w_en = reg_wr && reg_addr == dpc_pkg::OFS_PLL_ENABLE_BIAS;
    wire logic w_filt = reg_wr && reg_addr == dpc_pkg::OFS_LOOP_FILTER_AND_VTUNE;
    a_bypass_route: assert property (!pll_enable && ref_tick |=> sample_tick)
        else $error("bypass tick lost");
    a_tick_cause: assert property (sample_tick |-> $past(pll_enable ? pll_tick : ref_tick))
        else $error("sample tick from wrong source");
    a_data_cause: assert property (data_tick |-> $past(sample_tick))
        else $error("data tick without sample tick");
    a_band_load: assert property (w_band && reg_wdata[7:2] != dpc_pkg::BAND_AUTO |=>
        vco_band == $past(reg_wdata[7:2]) && !search_busy) else $error("band not loaded");
    a_search_start: assert property (w_band && reg_wdata[7:2] == dpc_pkg::BAND_AUTO |=>
        search_busy && vco_band == 6'h00) else $error("search did not start");
    a_enable_load: assert property (w_en |=> pll_enable == $past(reg_wdata[7]) &&
        pll_bias == $past(reg_wdata[2:0])) else $error("enable or bias not loaded");
    a_filter_load: assert property (w_filt |=> filter_zero_code == $past(reg_wdata[4:0]))
        else $error("filter code not loaded");
    a_vtune_read: assert property ($past(arst_n, 3) && reg_addr == 8'h0a &&
        $past(reg_addr) == 8'h0a && $past(vtune_level) == vtune_level &&
        $past(vtune_level, 2) == vtune_level |-> reg_rdata[7:5] == vtune_level)
        else $error("control voltage readback wrong");
    a_busy_read: assert property ($past(search_busy) && $past(reg_addr) == 8'h08 |->
        reg_rdata[7:2] == dpc_pkg::BAND_AUTO) else $error("busy band readback wrong");
endmodule : dpc_clock_config_chk
bind dpc_clock_config dpc_clock_config_chk chk_u (.clk_sys(clk_sys), .arst_n(arst_n),
    .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .ref_tick(ref_tick), .pll_tick(pll_tick), .vtune_level(vtune_level),
    .interp_sel(interp_sel), .sample_tick(sample_tick), .data_tick(data_tick),
    .pll_enable(pll_enable), .pll_bias(pll_bias), .vco_band(vco_band),
    .filter_zero_code(filter_zero_code), .search_busy(search_busy));
`default_nettype wire

// ==== test/test_dpc_clock_config.sv ====
// Self-checking bench for the clock configuration block
`timescale 1ns/1ns
`default_nettype none
module test_dpc_clock_config;
    logic clk_sys = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, ref_tick = 1'b0, pll_tick = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic [2:0] vtune_level = 3'h2, pll_bias;
    logic [1:0] interp_sel = 2'b00;
    logic sample_tick, data_tick, pll_enable, search_busy;
    logic [5:0] vco_band;
    logic [4:0] filter_zero_code;
    int fail_count = 0, num_checks = 0, n_data = 0, cyc = 0, lock_mode = 0;
    dpc_clock_config #(.SETTLE_CYCLES(4)) dut_u (.clk_sys(clk_sys), .arst_n(arst_n),
        .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .ref_tick(ref_tick), .pll_tick(pll_tick), .vtune_level(vtune_level),
        .interp_sel(interp_sel), .sample_tick(sample_tick), .data_tick(data_tick),
        .pll_enable(pll_enable), .pll_bias(pll_bias), .vco_band(vco_band),
        .filter_zero_code(filter_zero_code), .search_busy(search_busy));
    always #10 clk_sys = ~clk_sys;
    // Search mode 1 locks on bands 20 and 40 only, mode 2 never locks; 2 is healthy, 5 is not
    // Both locking bands keep the VCO inside its legal range
    always @(negedge clk_sys) if (lock_mode != 0) begin
        vtune_level <= (lock_mode == 1 && (vco_band == 6'h14 || vco_band == 6'h28)) ?
            3'h2 : 3'h5;
    end
    always @(posedge clk_sys) begin
        cyc++;
        if (data_tick === 1'b1) n_data++;
        if (cyc == 3000) begin
            fail_count++;
            print_verdict();
        end
    end
    task automatic print_verdict;
        $display("Checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : print_verdict
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk_sys);
        reg_wr = 1'b0;
    endtask : wr
    // Three cycles cover the registered read plus the delayed voltage image
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk_sys);
        reg_addr = a;
        repeat (3) @(negedge clk_sys);
        chk("reg_rdata", reg_rdata, exp);
    endtask : rd
    task automatic pulse(input logic p, input logic r, input logic exp);
        @(negedge clk_sys);
        pll_tick = p;
        ref_tick = r;
        @(negedge clk_sys);
        pll_tick = 1'b0;
        ref_tick = 1'b0;
        chk("sample_tick", {7'h00, sample_tick}, {7'h00, exp});
    endtask : pulse
    task automatic t_regs;
        rd(8'h08, 8'h00);
        rd(8'h09, 8'h00);
        wr(8'h09, 8'hff);
        rd(8'h09, 8'h87);
        chk("pll_bias", {5'h00, pll_bias}, 8'h07);
        chk("pll_enable", {7'h00, pll_enable}, 8'h01);
        wr(8'h0a, 8'h1f);
        rd(8'h0a, 8'h5f);
        chk("filter_zero_code", {3'h0, filter_zero_code}, 8'h1f);
        wr(8'h08, 8'hf9);
        rd(8'h08, 8'hf8);
        chk("vco_band", {2'b00, vco_band}, 8'h3e);
        wr(8'h0b, 8'hff);
        rd(8'h0b, 8'h00);
        rd(8'h07, 8'h00);
        $display("regs done");
    endtask : t_regs
    task automatic t_route;
        wr(8'h09, 8'h07);
        pulse(1'b1, 1'b0, 1'b0);
        pulse(1'b0, 1'b1, 1'b1);
        wr(8'h09, 8'h87);
        pulse(1'b0, 1'b1, 1'b0);
        pulse(1'b1, 1'b0, 1'b1);
        wr(8'h09, 8'h07);
        for (int s = 0; s < 4; s++) begin
            interp_sel = s[1:0];
            repeat (8) pulse(1'b0, 1'b1, 1'b1);
            repeat (2) @(negedge clk_sys);
            n_data = 0;
            repeat (16) pulse(1'b0, 1'b1, 1'b1);
            repeat (2) @(negedge clk_sys);
            chk("data_tick count", n_data[7:0], 8'h10 >> s);
        end
        // Loop closed: the divider now counts multiplier ticks
        wr(8'h09, 8'h87);
        interp_sel = 2'b01;
        repeat (8) pulse(1'b1, 1'b0, 1'b1);
        repeat (2) @(negedge clk_sys);
        n_data = 0;
        repeat (16) pulse(1'b1, 1'b0, 1'b1);
        repeat (2) @(negedge clk_sys);
        chk("locked data_tick count", n_data[7:0], 8'h08);
        $display("route done");
    endtask : t_route
    task automatic t_search(input int mode, input logic [5:0] exp);
        int n;
        n = 0;
        lock_mode = mode;
        wr(8'h08, 8'hfc);
        while (search_busy === 1'b1 && n < 400) begin
            @(negedge clk_sys);
            n++;
            if (n == 10) chk("busy readback", reg_rdata, 8'hfc);
        end
        chk("search cycles", n[7:0], 8'hfd);
        repeat (2) @(negedge clk_sys);
        chk("found band", reg_rdata, {exp, 2'b00});
        chk("vco_band", {2'b00, vco_band}, {2'b00, exp});
        wr(8'h08, {exp, 2'b00});
        rd(8'h08, {exp, 2'b00});
        chk("manual busy", {7'h00, search_busy}, 8'h00);
        lock_mode = 0;
        $display("search done");
    endtask : t_search
    task automatic t_abort;
        wr(8'h08, 8'hfc);
        repeat (5) @(negedge clk_sys);
        wr(8'h08, 8'h14);
        chk("abort", {1'b0, search_busy, vco_band}, 8'h05);
        $display("abort done");
    endtask : t_abort
    initial begin
        repeat (3) @(negedge clk_sys);
        arst_n = 1'b1;
        t_regs();
        t_route();
        t_search(1, 6'h28);
        t_search(2, 6'h00);
        t_abort();
        print_verdict();
    end
endmodule : test_dpc_clock_config
`default_nettype wire
